// file: logic/adt_pkg.sv
// Package for the left-channel gain decay and debounce timing bank.
// Assumes an APB slave with 32-bit data and word-aligned registers.
`default_nettype none
package adt_pkg;
    // Bus widths
    localparam int ADT_AW = 12;
    localparam int ADT_DW = 32;
    // Register indexes; byte address is four times the index
    localparam logic [ADT_AW-1:0] ADT_IDX_DECAY = 12'h005a;
    localparam logic [ADT_AW-1:0] ADT_IDX_NOISE = 12'h005b;
    localparam logic [ADT_AW-1:0] ADT_IDX_SIGNAL = 12'h005c;
    localparam logic [ADT_AW-1:0] ADT_IDX_THRESH = 12'h0060;
    localparam logic [ADT_AW-1:0] ADT_IDX_STATUS = 12'h0061;
    localparam int ADT_IDX_SHIFT = 2;
    // Reset values
    localparam logic [7:0] ADT_RST_DECAY = 8'h00;
    localparam logic [4:0] ADT_RST_NOISE = 5'h00;
    localparam logic [3:0] ADT_RST_SIGNAL = 4'h0;
    localparam logic [4:0] ADT_RST_THRESH = 5'h00;
    // Field layout
    localparam int ADT_DTIME_LSB = 3;
    localparam int ADT_DTIME_W = 5;
    localparam int ADT_DSCALE_W = 3;
    localparam int ADT_NDB_W = 5;
    localparam int ADT_SDB_W = 4;
    localparam int ADT_THR_W = 5;
    // Timing units, in ADC word clocks
    localparam int ADT_TW = 23;
    localparam int ADT_DECAY_UNIT_SH = 9;
    localparam int ADT_DB_UNIT = 4;
    localparam int ADT_NDB_STEP = 4096;
    localparam int ADT_NDB_MAX = 20;
    localparam int ADT_SDB_STEP = 2048;

    // Decay: (2n+1)*512 scaled by 2^s
    function automatic logic [ADT_TW-1:0] adt_decay_len(
        input logic [ADT_DTIME_W-1:0] n, input logic [ADT_DSCALE_W-1:0] s);
        logic [ADT_TW-1:0] base;
        base = ADT_TW'({n, 1'b1}) << ADT_DECAY_UNIT_SH;
        return base << s;
    endfunction

    // Noise debounce: doubling from 4, then multiples of 4096
    function automatic logic [ADT_TW-1:0] adt_noise_len(
        input logic [ADT_NDB_W-1:0] c);
        logic [ADT_TW-1:0] v;
        v = '0;
        if (c <= 5'h01) begin
            v = '0;
        end else if (c <= 5'h09) begin
            v = ADT_TW'(ADT_DB_UNIT) << (c - 5'h02);
        end else if (c == 5'h0a) begin
            v = ADT_TW'(ADT_NDB_STEP / 2);
        end else if (c - 5'h0a >= 5'(ADT_NDB_MAX)) begin
            v = ADT_TW'(ADT_NDB_MAX * ADT_NDB_STEP);
        end else begin
            v = ADT_TW'(c - 5'h0a) * ADT_TW'(ADT_NDB_STEP);
        end
        return v;
    endfunction

    // Signal debounce: doubling from 4, then multiples of 2048
    function automatic logic [ADT_TW-1:0] adt_signal_len(
        input logic [ADT_SDB_W-1:0] c);
        logic [ADT_TW-1:0] v;
        v = '0;
        case (c)
            4'h0, 4'h1: v = '0;
            4'h9: v = ADT_TW'(ADT_SDB_STEP / 2);
            4'ha: v = ADT_TW'(ADT_SDB_STEP);
            4'hb: v = ADT_TW'(2 * ADT_SDB_STEP);
            4'hc: v = ADT_TW'(3 * ADT_SDB_STEP);
            4'hd: v = ADT_TW'(5 * ADT_SDB_STEP);
            4'he, 4'hf: v = ADT_TW'(6 * ADT_SDB_STEP);
            default: v = ADT_TW'(ADT_DB_UNIT) << (c - 4'h2);
        endcase
        return v;
    endfunction
endpackage
`default_nettype wire

// file: logic/adt_timer.sv
// Word-clock interval timer shared by the decay and debounce paths.
// Assumes tick is a one-cycle pulse on pclk, once per sample frame.
`default_nettype none
module adt_timer #(
    parameter int W = 23
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic restart,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    // Result
    output logic done
);
    logic [W-1:0] cnt_r;

    // Counts whole frames; saturates so a long hold cannot wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (restart) begin
            cnt_r <= '0;
        end else if (tick && cnt_r < limit) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Zero limit means done at once
    assign done = (cnt_r >= limit);
endmodule
`default_nettype wire

// file: logic/adt_top.sv
// Gain decay and noise/signal debounce timing bank with APB registers.
// Assumes decay_req and noise_cond come from the gain engine on pclk,
// and adc_wclk is the asynchronous ADC word clock pin.
`default_nettype none
module adt_top
    import adt_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADT_AW-1:0] paddr,
    input wire logic [ADT_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    // APB answer
    output logic pready,
    output logic [ADT_DW-1:0] prdata,
    output logic pslverr,
    // ADC word clock pin
    input wire logic adc_wclk,
    // Gain engine conditions
    input wire logic decay_req,
    input wire logic noise_cond,
    // Timing results
    output logic decay_step,
    output logic noise_gate
);
    typedef enum logic [2:0] {
        ADT_G_IDLE = 3'b001,
        ADT_G_GATED = 3'b010,
        ADT_G_OFF = 3'b100
    } adt_gate_t;

    logic [7:0] decay_r;
    logic [ADT_NDB_W-1:0] noise_db_r;
    logic [ADT_SDB_W-1:0] signal_db_r;
    logic [ADT_THR_W-1:0] thresh_r;
    logic pready_r;
    logic [ADT_DW-1:0] prdata_r;
    logic pslverr_r;
    logic [2:0] wclk_r;
    logic decay_req_r;
    logic decay_step_r;
    adt_gate_t gate_r;
    logic noise_gate_r;
    logic gate_nxt;
    logic cfg_wr;
    logic wclk_tick;
    logic decay_done;
    logic noise_done;
    logic signal_done;
    logic decay_restart;
    logic noise_restart;
    logic signal_restart;
    logic [ADT_TW-1:0] decay_len;
    logic [ADT_TW-1:0] noise_len;
    logic [ADT_TW-1:0] signal_len;
    logic access;
    logic mapped;
    logic [ADT_AW-1:0] idx;

    // Address decode; word index from byte address
    function automatic logic adt_hit(input logic [ADT_AW-1:0] a,
                                     input logic [ADT_AW-1:0] i);
        return (a[1:0] == 2'b00) && ((a >> ADT_IDX_SHIFT) == i);
    endfunction

    assign idx = paddr >> ADT_IDX_SHIFT;
    assign access = psel && penable;
    assign mapped = adt_hit(paddr, ADT_IDX_DECAY)
                 || adt_hit(paddr, ADT_IDX_NOISE)
                 || adt_hit(paddr, ADT_IDX_SIGNAL)
                 || adt_hit(paddr, ADT_IDX_THRESH)
                 || adt_hit(paddr, ADT_IDX_STATUS);
    // Write lands only at the edge where pready is seen high
    assign cfg_wr = access && pready_r && pwrite && pstrb[0] && mapped;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= access && !pready_r;
        end
    end

    // Read data and error captured with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else if (access && !pready_r) begin
            pslverr_r <= !mapped;
            prdata_r <= '0;
            if (!pwrite) begin
                if (adt_hit(paddr, ADT_IDX_DECAY)) begin
                    prdata_r <= ADT_DW'(decay_r);
                end else if (adt_hit(paddr, ADT_IDX_NOISE)) begin
                    prdata_r <= ADT_DW'(noise_db_r);
                end else if (adt_hit(paddr, ADT_IDX_SIGNAL)) begin
                    prdata_r <= ADT_DW'(signal_db_r);
                end else if (adt_hit(paddr, ADT_IDX_THRESH)) begin
                    prdata_r <= ADT_DW'(thresh_r);
                end else if (adt_hit(paddr, ADT_IDX_STATUS)) begin
                    prdata_r <= ADT_DW'({decay_req_r, gate_r});
                end
            end
        end else begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end
    end

    // Configuration registers; upper debounce bits are not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decay_r <= ADT_RST_DECAY;
            noise_db_r <= ADT_RST_NOISE;
            signal_db_r <= ADT_RST_SIGNAL;
            thresh_r <= ADT_RST_THRESH;
        end else if (cfg_wr) begin
            if (idx == ADT_IDX_DECAY) begin
                decay_r <= pwdata[7:0];
            end else if (idx == ADT_IDX_NOISE) begin
                noise_db_r <= pwdata[ADT_NDB_W-1:0];
            end else if (idx == ADT_IDX_SIGNAL) begin
                signal_db_r <= pwdata[ADT_SDB_W-1:0];
            end else if (idx == ADT_IDX_THRESH) begin
                thresh_r <= pwdata[ADT_THR_W-1:0];
            end
        end
    end

    // Word clock pin: two-flop sync, third flop for the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wclk_r <= '0;
        end else begin
            wclk_r <= {wclk_r[1:0], adc_wclk};
        end
    end
    assign wclk_tick = wclk_r[1] && !wclk_r[2];

    // Interval lengths from the codes
    assign decay_len = adt_decay_len(decay_r[ADT_DTIME_LSB +: ADT_DTIME_W],
                                     decay_r[ADT_DSCALE_W-1:0]);
    assign noise_len = adt_noise_len(noise_db_r);
    assign signal_len = adt_signal_len(signal_db_r);

    // Decay restarts on request change, on each step and on reprogram
    assign decay_restart = (decay_req != decay_req_r) || decay_step_r
                        || !decay_req
                        || (cfg_wr && idx == ADT_IDX_DECAY);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decay_req_r <= 1'b0;
            decay_step_r <= 1'b0;
        end else begin
            decay_req_r <= decay_req;
            decay_step_r <= decay_req && decay_req_r && decay_done
                         && !decay_step_r;
        end
    end

    // Debounce timers run only while their condition holds
    assign noise_restart = !(gate_r == ADT_G_IDLE && noise_cond);
    assign signal_restart = !(gate_r == ADT_G_GATED && !noise_cond);

    // Noise gate: debounced entry, debounced exit
    always_comb begin
        gate_nxt = 1'b0;
        case (gate_r)
            ADT_G_IDLE: gate_nxt = noise_cond && noise_done;
            ADT_G_GATED: gate_nxt = !(!noise_cond && signal_done);
            default: gate_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_r <= ADT_G_OFF;
            noise_gate_r <= 1'b0;
        end else if (thresh_r == ADT_RST_THRESH) begin
            gate_r <= ADT_G_OFF;
            noise_gate_r <= 1'b0;
        end else if (gate_r == ADT_G_OFF) begin
            gate_r <= ADT_G_IDLE;
            noise_gate_r <= 1'b0;
        end else begin
            // Output flop mirrors the gated state, no decode on the pin
            gate_r <= gate_nxt ? ADT_G_GATED : ADT_G_IDLE;
            noise_gate_r <= gate_nxt;
        end
    end

    // Timer instances
    adt_timer #(.W(ADT_TW)) u_decay (
        .pclk(pclk),
        .presetn(presetn),
        .restart(decay_restart),
        .tick(wclk_tick),
        .limit(decay_len),
        .done(decay_done)
    );
    adt_timer #(.W(ADT_TW)) u_noise (
        .pclk(pclk),
        .presetn(presetn),
        .restart(noise_restart),
        .tick(wclk_tick),
        .limit(noise_len),
        .done(noise_done)
    );
    adt_timer #(.W(ADT_TW)) u_signal (
        .pclk(pclk),
        .presetn(presetn),
        .restart(signal_restart),
        .tick(wclk_tick),
        .limit(signal_len),
        .done(signal_done)
    );

    // Outputs straight from flops
    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign decay_step = decay_step_r;
    assign noise_gate = noise_gate_r;
endmodule
`default_nettype wire

// file: sim/adt_top_props.sv
// Checker for the timing bank: APB answer timing and timing outputs.
// Assumes it is bound to adt_top and sees only that module's ports.
`default_nettype none
module adt_top_chk
    import adt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request and answer
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADT_AW-1:0] paddr,
    input wire logic pready,
    input wire logic [ADT_DW-1:0] prdata,
    input wire logic pslverr,
    // Gain engine side
    input wire logic decay_req,
    input wire logic noise_cond,
    input wire logic decay_step,
    input wire logic noise_gate
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Answer comes one wait state into the access phase, for one cycle
    property p_wait; $rose(penable) && psel |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no answer after wait");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("pready longer than 1");
    property p_req; pready |-> psel && penable; endproperty
    a_req: assert property (p_req) else $error("pready without access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_idle; !pready |-> prdata == '0; endproperty
    a_idle: assert property (p_idle) else $error("prdata not zero idle");
    // Reserved upper bits of the debounce registers always read zero
    property p_upn; pready && !pwrite && paddr == (ADT_IDX_NOISE << 2)
        |-> prdata[31:5] == '0; endproperty
    a_upn: assert property (p_upn) else $error("noise upper bits");
    property p_ups; pready && !pwrite && paddr == (ADT_IDX_SIGNAL << 2)
        |-> prdata[31:4] == '0; endproperty
    a_ups: assert property (p_ups) else $error("signal upper bits");
    // Decay step is a single pulse and needs a held request
    property p_step; decay_step |=> !decay_step; endproperty
    a_step: assert property (p_step) else $error("step too long");
    property p_sreq; decay_step |-> $past(decay_req); endproperty
    a_sreq: assert property (p_sreq) else $error("step without req");
    // Gate changes only follow the matching condition
    property p_gon; $rose(noise_gate) |-> $past(noise_cond); endproperty
    a_gon: assert property (p_gon) else $error("gate without cond");
    // A threshold write may end gating whatever the condition is
    property p_goff; $fell(noise_gate)
        && !$past(pready && pwrite && paddr == (ADT_IDX_THRESH << 2), 2)
        |-> !$past(noise_cond); endproperty
    a_goff: assert property (p_goff) else $error("ungate with cond");
endmodule

bind adt_top adt_top_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .decay_req(decay_req), .noise_cond(noise_cond),
    .decay_step(decay_step), .noise_gate(noise_gate));
`default_nettype wire

// file: sim/test_agc_decay_debounce_timing.sv
// Self-checking bench for the gain decay and debounce timing bank.
// Assumes adt_pkg, adt_top and its bound checker are compiled first.
`default_nettype none
module test_agc_decay_debounce_timing
    import adt_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADT_AW-1:0] paddr = '0;
    logic [ADT_DW-1:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, decay_step, noise_gate, err;
    logic decay_req = 0, noise_cond = 0;
    logic [1:0] ph = 2'h0;
    int tick_cnt = 0, error_cnt = 0, checks = 0, t;

    // 20 MHz bus clock
    always #25 pclk = ~pclk;
    // Word clock at a quarter rate, slow enough for the pin synchroniser
    always @(posedge pclk) begin
        ph <= ph + 2'h1;
        if (ph == 2'h1) tick_cnt <= tick_cnt + 1;
    end

    adt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .adc_wclk(ph[1]), .decay_req(decay_req), .noise_cond(noise_cond),
        .decay_step(decay_step), .noise_gate(noise_gate));

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Tick count may slip by one frame through the pin synchroniser
    task automatic near(input string what, input int l);
        chk(what, (t + 1 >= l && t <= l + 1) ? 32'(l) : 32'(t), 32'(l));
    endtask

    // One APB transfer; an idle cycle follows so signals never clash
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] st);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n == 20) begin
            error_cnt++;
            close_out();
        end
    endtask

    // Counts word clock ticks until the chosen output reaches lvl
    task automatic wt(input logic dec, input logic lvl);
        int n, t0;
        t0 = tick_cnt;
        n = 0;
        while ((dec ? decay_step : noise_gate) !== lvl && n < 30000) begin
            @(posedge pclk);
            n++;
        end
        t = tick_cnt - t0;
        if (n == 30000) begin
            error_cnt++;
            close_out();
        end
    endtask

    task automatic t_regs();
        logic [11:0] ad [3] = '{ADT_IDX_DECAY, ADT_IDX_NOISE, ADT_IDX_SIGNAL};
        logic [31:0] m [3] = '{32'h0000_00ff, 32'h0000_001f, 32'h0000_000f};
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, ad[i] << ADT_IDX_SHIFT, 32'h0, 4'hf);
            chk("reset value", rd, 32'h0);
            // Reserved upper bits are written as zero only
            apb(1'b1, ad[i] << ADT_IDX_SHIFT, m[i], 4'hf);
            apb(1'b0, ad[i] << ADT_IDX_SHIFT, 32'h0, 4'hf);
            chk("read back", rd, m[i]);
            apb(1'b1, ad[i] << ADT_IDX_SHIFT, 32'h0, 4'h0);
            apb(1'b0, ad[i] << ADT_IDX_SHIFT, 32'h0, 4'hf);
            chk("strobe off", rd, m[i]);
        end
        apb(1'b0, 12'h000, 32'h0, 4'hf);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_off();
        apb(1'b1, ADT_IDX_NOISE << ADT_IDX_SHIFT, 32'h1, 4'hf);
        noise_cond <= 1'b1;
        repeat (40) @(posedge pclk);
        chk("gate disabled", {31'h0, noise_gate}, 32'h0);
        noise_cond <= 1'b0;
        @(posedge pclk);
        $display("test gate off done");
    endtask

    task automatic t_decay();
        logic [7:0] cf [3] = '{8'h00, 8'h08, 8'h02};
        int len [3] = '{512, 1536, 2048};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADT_IDX_DECAY << ADT_IDX_SHIFT, {24'h0, cf[i]}, 4'hf);
            decay_req <= 1'b1;
            wt(1'b1, 1'b1);
            near("decay first", len[i]);
            @(posedge pclk);
            wt(1'b1, 1'b1);
            near("decay period", len[i]);
            decay_req <= 1'b0;
            @(posedge pclk);
        end
        $display("test decay done");
    endtask

    task automatic t_gate();
        logic [31:0] nc [3] = '{32'h1, 32'h2, 32'ha};
        logic [31:0] sc [3] = '{32'h1, 32'h3, 32'h9};
        int nl [3] = '{0, 4, 2048};
        int sl [3] = '{0, 8, 1024};
        apb(1'b1, ADT_IDX_THRESH << ADT_IDX_SHIFT, 32'h1, 4'hf);
        apb(1'b0, ADT_IDX_THRESH << ADT_IDX_SHIFT, 32'h0, 4'hf);
        chk("threshold", rd, 32'h1);
        // Status shows the one-hot idle state once the gate is armed
        apb(1'b0, ADT_IDX_STATUS << ADT_IDX_SHIFT, 32'h0, 4'hf);
        chk("status idle", rd, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADT_IDX_NOISE << ADT_IDX_SHIFT, nc[i], 4'hf);
            apb(1'b1, ADT_IDX_SIGNAL << ADT_IDX_SHIFT, sc[i], 4'hf);
            noise_cond <= 1'b1;
            wt(1'b0, 1'b1);
            near("noise debounce", nl[i]);
            noise_cond <= 1'b0;
            wt(1'b0, 1'b0);
            near("signal debounce", sl[i]);
        end
        $display("test gate done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_off();
        t_decay();
        t_gate();
        close_out();
    end
endmodule
`default_nettype wire
